//--- acd_seq.sv
// cable detect sequencer top
// Operation
// RQ1: the external reset driver holds reset at least 100 us after supply reaches 90 percent.
// RQ2: the reference clock is valid for at least the last 60 us of reset.
// RQ3: reset should be stretched to about 2 ms since the oscillator needs about 1 ms.
// RQ4: the bridge must signal USB attach within 100 ms of drawing bus power.
// RQ5: a drive takes number 0 with cable select negated and 1 with it asserted.
// RQ6: the drive width indicator is ignored and transfers are always 16 bits.
// RQ7: device 1 asserts the diag passed line when its diagnostics finish.
// RQ8: modes above ultra-DMA 2 are allowed only after an 80-conductor cable is confirmed.
// RQ9: an 80-conductor cable is concluded only when the cable type line reads ground.
// RQ10: the cable line is sampled only after reset protocol completes on every drive.
// RQ11: with device 1 present, identify data must show ATA-3 or later before sampling.
// RQ12: an ATA-3 or later drive releases diag passed by the end of its first command.
// RQ13: the shared diag and cable line is read through bit 6 of general port 3.
// RQ14: the result is recorded and the ultra-DMA cap stays at mode 2 without the cable.
`include "acd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module acd_seq
	import acd_pkg::*;
#(
	parameter int unsigned ATTACH_CYC = `ACD_ATTACH_CYC
) (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       ce,
	input  wire logic [7:0]                 gp_port3,
	input  wire logic                       drives_reset_done,
	input  wire logic                       dev1_present,
	input  wire logic                       ident_valid,
	input  wire logic [3:0]                 dev1_ata_ver,
	input  wire logic                       boot_done,
	input  wire logic                       wide_transfer_indicator,
	output logic                            usb_attach,
	output logic                            attach_late,
	output logic                            cable_80_q,
	output logic                            detect_done,
	output logic [`ACD_UDMA_MAX_W-1:0]      udma_cap,
	output logic                            wide_16bit
);
	// ****************************************
	// input synchronisation
	// ****************************************
	acd_sync_if sif ();
	assign sif.line_raw = gp_port3[`ACD_GP3_CBL_BIT]; // RQ13
	acd_sync u_sync (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.sif    (sif)
	);
	logic rdy_s1_q;
	logic rdy_s2_q;
	// drive reset status comes from firmware pins, so resynchronise it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
		end else if (ce) begin
			rdy_s1_q <= drives_reset_done;
			rdy_s2_q <= rdy_s1_q;
		end
	end

	// ****************************************
	// usb attach deadline
	// ****************************************
	logic [31:0] att_cnt_q;
	logic        att_q;
	logic        late_q;
	wire         att_expired = (att_cnt_q >= ATTACH_CYC - 1);
	// counter runs from reset release; boot beyond it flags a late attach
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			att_cnt_q <= 32'h0;
			att_q     <= 1'b0;
			late_q    <= 1'b0;
		end else if (ce) begin
			if (!att_expired && !att_q)
				att_cnt_q <= att_cnt_q + 32'h1;
			if (boot_done || att_expired)
				att_q <= 1'b1; // RQ4
			if (att_expired && !boot_done && !att_q)
				late_q <= 1'b1;
		end
	end
	assign usb_attach  = att_q;
	assign attach_late = late_q;

	// ****************************************
	// cable detection sequence
	// ****************************************
	acd_state_t st_q, st_d;
	logic       c80_q, c80_d;
	wire        ver_ok   = ident_valid && (dev1_ata_ver >= `ACD_ATA_MIN_VER); // RQ11
	wire        line_gnd = !sif.line_sync; // RQ9
	// diag passed may still be held low by an old drive, so gate sampling
	always_comb begin
		st_d  = st_q;
		c80_d = c80_q;
		case (st_q)
			ACD_IDLE: begin
				st_d = ACD_WRST;
			end
			ACD_WRST: begin
				if (rdy_s2_q) begin // RQ10
					st_d = dev1_present ? ACD_WID : ACD_SAMP;
				end
			end
			ACD_WID: begin
				if (ident_valid) begin
					st_d = ver_ok ? ACD_SAMP : ACD_FAIL; // RQ11 RQ12
				end
			end
			ACD_SAMP: begin
				c80_d = line_gnd; // RQ9
				st_d  = ACD_DONE;
			end
			ACD_DONE: begin
				st_d = ACD_DONE;
			end
			ACD_FAIL: begin
				c80_d = 1'b0; // cannot trust the line, assume 40-wire
				st_d  = ACD_DONE;
			end
			default: begin
				st_d = ACD_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q  <= ACD_IDLE;
			c80_q <= 1'b0;
		end else if (ce) begin
			st_q  <= st_d;
			c80_q <= c80_d; // RQ14
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	logic [`ACD_UDMA_MAX_W-1:0] cap_q;
	// cap stays at mode 2 until a confirmed 80-conductor result
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			cap_q <= `ACD_UDMA_CAP_40;
		else if (ce)
			cap_q <= (st_q == ACD_DONE && c80_q) ? `ACD_UDMA_CAP_80 : `ACD_UDMA_CAP_40; // RQ8 RQ14
	end
	assign cable_80_q  = c80_q;
	assign detect_done = (st_q == ACD_DONE);
	assign udma_cap    = cap_q;
	assign wide_16bit  = 1'b1; // RQ6

	// ****************************************
	// checks
	// ****************************************
	cap_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		(cap_q > `ACD_UDMA_CAP_40) |-> c80_q && $past(st_q == ACD_DONE)) else $error("cap above 2 without cable"); // RQ8
	samp_after_rst_a: assert property (@(posedge clk) disable iff (!resetn)
		(st_q == ACD_SAMP) |-> $past(rdy_s2_q) || $past(st_q == ACD_WID)) else $error("sampled before reset done"); // RQ10
	gnd_only_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && (st_q == ACD_SAMP) |=> (c80_q == !$past(sif.line_sync))) else $error("cable result wrong"); // RQ9
	ver_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && (st_q == ACD_WID) && ident_valid && !ver_ok |=> st_q == ACD_FAIL) else $error("old drive sampled"); // RQ11
	fail_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		ce && (st_q == ACD_FAIL) |=> !c80_q ##1 cap_q == `ACD_UDMA_CAP_40) else $error("fail kept cable"); // RQ14
	attach_by_a: assert property (@(posedge clk) disable iff (!resetn)
		att_expired && ce |=> usb_attach) else $error("attach deadline missed"); // RQ4
	width_a: assert property (@(posedge clk) disable iff (!resetn)
		wide_16bit) else $error("width not 16"); // RQ6
	sync_line_a: assert property (@(posedge clk) disable iff (!resetn)
		ce ##1 ce ##1 ce |-> sif.line_sync == $past(gp_port3[`ACD_GP3_CBL_BIT], 2)) else $error("sync path broken"); // RQ13
	c80_cv: cover property (@(posedge clk) disable iff (!resetn) detect_done && c80_q);
	c40_cv: cover property (@(posedge clk) disable iff (!resetn) detect_done && !c80_q);
	fail_cv: cover property (@(posedge clk) disable iff (!resetn) st_q == ACD_FAIL);
endmodule
`default_nettype wire

//--- acd_defines.svh
// timing counts and field constants for the cable detect sequencer
`ifndef ACD_DEFINES_SVH
`define ACD_DEFINES_SVH
`define ACD_CLK_MHZ        40
`define ACD_ATTACH_MS      100
`define ACD_ATTACH_CYC     (`ACD_ATTACH_MS * 1000 * `ACD_CLK_MHZ)
`define ACD_UDMA_MAX_W     3
`define ACD_UDMA_CAP_40    3'h2
`define ACD_UDMA_CAP_80    3'h6
`define ACD_ATA_MIN_VER    4'h3
`define ACD_GP3_CBL_BIT    6
`endif

//--- acd_pkg.sv
// types for the cable detect sequencer
package acd_pkg;
	typedef enum logic [5:0] {
		ACD_IDLE  = 6'h01,
		ACD_WRST  = 6'h02,
		ACD_WID   = 6'h04,
		ACD_SAMP  = 6'h08,
		ACD_DONE  = 6'h10,
		ACD_FAIL  = 6'h20
	} acd_state_t;
endpackage

//--- acd_sync_if.sv
// interface carrying the synchronised cable line between modules
`timescale 1ns/1ps
`default_nettype none
interface acd_sync_if;
	logic line_raw;
	logic line_sync;
	modport syn (input line_raw, output line_sync);
	modport use_side (output line_raw, input line_sync);
endinterface
`default_nettype wire

//--- acd_sync.sv
// two-stage synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module acd_sync (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	acd_sync_if.syn   sif
);
	logic s1_q;
	logic s2_q;
	// first stage is read only by the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
		end else if (ce) begin
			s1_q <= sif.line_raw;
			s2_q <= s1_q;
		end
	end
	assign sif.line_sync = s2_q;
endmodule
`default_nettype wire

//--- acd_drive_model.sv
// behavioural drive pair: reset protocol, identify data, diag/cable line
`timescale 1ns/1ps
`default_nettype none
module acd_drive_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       cable80,
	input  wire logic       dev1,
	input  wire logic [3:0] ver,
	input  wire logic [5:0] rst_cyc,
	output logic            rst_done,
	output logic            ident_valid,
	output logic [3:0]      ata_ver,
	output logic            wide_ind,
	output logic            line_n
);
	logic [6:0] cnt_q;
	logic       diag_q;
	// pulled up unless the 80-wire cable grounds it or device 1 holds diag
	assign line_n = !(cable80 || diag_q);
	assign rst_done = cnt_q > {1'b0, rst_cyc};
	assign ident_valid = dev1 && (cnt_q > {1'b0, rst_cyc} + 7'h0A);
	assign ata_ver = ident_valid ? ver : ~ver; // stale data is garbage
	assign wide_ind = cnt_q[0];
	// old drives never let go of diag; a new one frees it once the identify
	// command is taken, well before its data turns valid, so the host's
	// synchronised view of the line has settled by the time it samples
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 7'h00;
			diag_q <= 1'b0;
		end else begin
			if (cnt_q != 7'h7F)
				cnt_q <= cnt_q + 7'h01;
			if (dev1 && cnt_q == {1'b0, rst_cyc})
				diag_q <= 1'b1;
			else if (dev1 && cnt_q == {1'b0, rst_cyc} + 7'h05 && ver >= 4'h3)
				diag_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- ata_cable_detect_sequencer_tb.sv
// self-checking bench for the cable detect sequencer
`include "acd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ata_cable_detect_sequencer_tb;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       boot_done = 1'b0;
	logic       cable80 = 1'b0;
	logic       dev1 = 1'b0;
	logic [3:0] ver = 4'h3;
	logic [5:0] rst_cyc = 6'h08;
	logic [7:0] gp_o = 8'hFF;
	logic       rdone, idv, wide, line_n, attach, late, c80, done, w16;
	logic [3:0] aver;
	logic [2:0] cap;
	logic [5:0] e;
	logic [5:0] exp_q[$];
	int         n_errors = 0;
	int         check_count = 0;
	event       res_ev;
	always #12.5 clk = ~clk;
	acd_drive_model drv (.clk(clk), .resetn(resetn), .cable80(cable80), .dev1(dev1), .ver(ver),
		.rst_cyc(rst_cyc), .rst_done(rdone), .ident_valid(idv), .ata_ver(aver), .wide_ind(wide),
		.line_n(line_n));
	acd_seq #(.ATTACH_CYC(50)) dut (.clk(clk), .resetn(resetn), .ce(1'b1),
		.gp_port3({gp_o[7], line_n, gp_o[5:0]}), .drives_reset_done(rdone), .dev1_present(dev1),
		.ident_valid(idv), .dev1_ata_ver(aver), .boot_done(boot_done), .wide_transfer_indicator(wide),
		.usb_attach(attach), .attach_late(late), .cable_80_q(c80), .detect_done(done),
		.udma_cap(cap), .wide_16bit(w16));
	task automatic check(string n, logic [3:0] s, logic [3:0] x);
		check_count++;
		if (s !== x) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one pass: random drives and cable, reset, then note the outcome
	task automatic run_one();
		logic ok;
		logic early;
		@(posedge clk);
		#2 resetn = 1'b0;
		boot_done = 1'b0;
		cable80 = 1'($urandom_range(1, 0));
		dev1 = 1'($urandom_range(1, 0));
		ver = 4'($urandom_range(5, 1));
		rst_cyc = 6'($urandom_range(40, 4));
		gp_o = 8'($urandom);
		early = 1'($urandom_range(1, 0));
		repeat (10) @(posedge clk);
		#2 resetn = 1'b1;
		ok = !(dev1 && ver < 4'h3);
		// a refused drive still ends the sequence, only without the cable
		exp_q.push_back({!early, 1'b1, cable80 && ok, cable80 && ok ? `ACD_UDMA_CAP_80 : `ACD_UDMA_CAP_40});
		repeat (3) @(posedge clk);
		#2 boot_done = early;
		check("early cable_80_q", 4'(c80), 4'h0);
		check("early udma_cap", 4'(cap), 4'(`ACD_UDMA_CAP_40));
		repeat (90) @(posedge clk);
		#2 -> res_ev;
	endtask
	// watcher takes the oldest note whenever a result is due
	always @(res_ev) begin
		e = exp_q.pop_front();
		check("attach_late", 4'(late), 4'(e[5]));
		check("usb_attach", 4'(attach), 4'h1);
		check("detect_done", 4'(done), 4'(e[4]));
		check("cable_80_q", 4'(c80), 4'(e[3]));
		check("udma_cap", 4'(cap), 4'(e[2:0]));
		check("wide_16bit", 4'(w16), 4'h1);
	end
	initial begin
		void'($urandom(56530));
		repeat (10) @(posedge clk);
		for (int t = 0; t < 24; t++)
			run_one();
		@(posedge clk);
		report_and_stop();
	end
	// hang guard: all passes take about 2500 cycles
	initial begin
		repeat (4000) @(posedge clk);
		n_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
